/* src/trp_pkg.sv */
/*
  Package for the receive packet port and credit report block.
  Holds register offsets, field positions, reset values, selector codes
  and the structs that carry a receive beat and a set of credit counts.
  Assumes nothing of its surroundings.
*/
`default_nettype none

package trp_pkg;

  // Register byte offsets on the APB slave.
  localparam logic [7:0] TRP_OFS_CTRL      = 8'h00;
  localparam logic [7:0] TRP_OFS_STATUS    = 8'h04;
  localparam logic [7:0] TRP_OFS_PKT_COUNT = 8'h08;

  // Control register fields and reset value.
  localparam int         TRP_CTRL_RX_EN_BIT = 0;
  localparam int         TRP_CTRL_PAIR_LSB  = 1;
  localparam logic [3:0] TRP_CTRL_RESET     = 4'h1;

  // Status register fields.
  localparam int TRP_STAT_LINK_UP_BIT = 0;
  localparam int TRP_STAT_PENDING_BIT = 1;
  localparam int TRP_STAT_MID_BIT     = 2;

  // Credit view selector codes.
  localparam logic [2:0] TRP_VIEW_RX_SPACE    = 3'h0;
  localparam logic [2:0] TRP_VIEW_RX_GRANTED  = 3'h1;
  localparam logic [2:0] TRP_VIEW_RX_CONSUMED = 3'h2;
  localparam logic [2:0] TRP_VIEW_TX_AVAIL    = 3'h4;
  localparam logic [2:0] TRP_VIEW_TX_LIMIT    = 3'h5;
  localparam logic [2:0] TRP_VIEW_TX_CONSUMED = 3'h6;
  localparam int         TRP_NUM_VIEWS        = 6;

  // Code of the active state of the link control state machine.
  localparam logic [2:0] TRP_LINK_ACTIVE_CODE = 3'h4;

  // Stages in the pin synchroniser.
  localparam int TRP_SYNC_STAGES = 2;

  // One set of credit counts for one view.
  typedef struct packed {
    logic [11:0] cpl_data_credits;
    logic [7:0]  cpl_header_credits;
    logic [11:0] np_data_credits;
    logic [7:0]  np_header_credits;
    logic [11:0] posted_data_credits;
    logic [7:0]  posted_header_credits;
  } trp_credit_set_t;

  // One receive beat with its side flags.
  typedef struct packed {
    logic [127:0] data;
    logic         sof;
    logic         eof;
    logic [6:0]   region_hit;
    logic         e2e_crc_error;
    logic         poisoned;
  } trp_beat_t;

endpackage

`default_nettype wire

/* src/trp_sync.sv */
/*
  Two flip-flop level synchroniser, parameterised in width.
  Assumes the input is a level or a pulse long enough to be seen at pclk.
*/
`timescale 1ns/1ps
`default_nettype none

module trp_sync
  import trp_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // The first stage feeds only the second stage to contain metastability.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stage1   <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

`default_nettype wire

/* src/trp_top.sv */
/*
  Receive packet port with credit reporting and an APB register slave.
  Internal queue beats pass one output register to the user, credit
  views are selected onto six counters, and a posted credit return
  pulse from the second user clock raises a pending request.
  Assumes the internal source keeps beats well formed and only changes
  a beat when src_ready was high, and that all internal inputs are on pclk.
*/
// Functional notes
// R1: Selector picks one of six credit views shown on every credit output.
// R2: Completion credits reported as 12-bit data and 8-bit header counts.
// R3: Non-posted credits reported as 12-bit data and 8-bit header counts.
// R4: Posted credits reported as 12-bit data and 8-bit header counts.
// R5: Link-up output high one cycle after each cycle the link state machine is active.
// R6: Seven-bit region hit vector, bit six is the expansion ROM region.
// R7: Paired 64-bit regions assert both hit bits together.
// R8: A beat transfers only when source valid and user ready are both high.
// R9: User raises ready only when it can take data that cycle.
// R10: CRC error flag raised on the end beat of a failing packet.
// R11: Poisoned flag held on every beat of a poisoned packet.
// R12: End-of-frame raised on the beat carrying final packet data.
// R13: Credit return pulse sets pending; sending the credits clears it.
// R14: Start-of-frame raised on the first beat of each packet.
// R15: User drops non-posted ok one cycle before last acceptable end.
// R16: Source abort ends the current packet when the link enters reset.
// R17: Credit outputs follow the selector sampled one cycle earlier.
`timescale 1ns/1ps
`default_nettype none

module trp_top
  import trp_pkg::*;
(
  input  wire logic            pclk,
  input  wire logic            presetn,
  // APB slave.
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [7:0]      paddr,
  input  wire logic [31:0]     pwdata,
  output var  logic [31:0]     prdata,
  output var  logic            pready,
  output var  logic            pslverr,
  // Internal receive queue side.
  input  wire trp_beat_t       src_beat,
  input  wire logic            src_valid,
  output var  logic            src_ready,
  input  wire logic            link_entering_reset,
  input  wire logic [2:0]      link_control_state_machine,
  // Internal credit sources and transmit side handshake.
  input  wire trp_credit_set_t credit_views [TRP_NUM_VIEWS],
  input  wire logic            posted_credits_sent,
  output var  logic            posted_return_pending,
  // User side.
  input  wire logic [2:0]      credit_view_select,
  output var  trp_credit_set_t credit_out,
  output var  logic            link_up_status,
  output var  logic [127:0]    rx_packet_data,
  output var  logic            rx_source_valid,
  input  wire logic            rx_user_ready,
  output var  logic            rx_start_of_frame,
  output var  logic            rx_end_of_frame,
  output var  logic [6:0]      rx_region_hit,
  output var  logic            rx_e2e_crc_error,
  output var  logic            rx_poisoned_flag,
  output var  logic            rx_source_abort,
  input  wire logic            nonposted_accept_ok,
  output var  logic            nonposted_hold,
  input  wire logic            posted_credit_return
);

  logic [3:0]      ctrl;
  logic [31:0]     pkt_count;
  logic            out_mid;
  logic            pkt_poison;
  logic            fire;
  logic            load;
  logic            ret_sync;
  logic            ret_prev;
  logic            ret_pulse;
  logic            apb_done;
  logic [6:0]      next_hit;
  trp_credit_set_t next_credit;

  // A beat leaves when both sides agree; the user keeps its own ready honest. R8 R9
  assign fire = rx_source_valid & rx_user_ready;
  // Accept from the queue when the output stage is free or draining.
  assign load = src_valid & src_ready;
  assign apb_done = psel & penable & pready;

  // Ready stays combinational so beats flow at full rate; the internal queue and the load term read it.
  always_comb
  begin
    src_ready = ctrl[TRP_CTRL_RX_EN_BIT] & ~link_entering_reset
                & (~rx_source_valid | rx_user_ready);
  end

  // Pairing spreads a hit onto its partner bit of a 64-bit window. R6
  always_comb
  begin
    next_hit = src_beat.region_hit;
    for (int k = 0; k < 3; k++)
    begin
      if (ctrl[TRP_CTRL_PAIR_LSB + k] &
          (src_beat.region_hit[2*k] | src_beat.region_hit[2*k+1]))
      begin
        next_hit[2*k]   = 1'b1; // R7
        next_hit[2*k+1] = 1'b1; // R7
      end
    end
  end

  // Output beat register; held while the user stalls.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_source_valid   <= 1'b0;
      rx_packet_data    <= '0;
      rx_start_of_frame <= 1'b0;
      rx_end_of_frame   <= 1'b0;
      rx_region_hit     <= '0;
      rx_e2e_crc_error  <= 1'b0;
      rx_poisoned_flag  <= 1'b0;
    end
    else if (link_entering_reset)
    begin
      rx_source_valid <= 1'b0; // R16
    end
    else if (load)
    begin
      rx_source_valid   <= 1'b1;
      rx_packet_data    <= src_beat.data;
      rx_start_of_frame <= src_beat.sof; // R14
      rx_end_of_frame   <= src_beat.eof; // R12
      rx_region_hit     <= next_hit; // R6
      rx_e2e_crc_error  <= src_beat.e2e_crc_error & src_beat.eof; // R10
      // Poison seen at the start covers the rest of the packet. R11
      rx_poisoned_flag  <= src_beat.poisoned | (pkt_poison & ~src_beat.sof);
    end
    else if (fire)
    begin
      rx_source_valid <= 1'b0; // R8
    end
  end

  // Poison memory for the packet entering the output stage.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pkt_poison <= 1'b0;
    end
    else if (link_entering_reset)
    begin
      pkt_poison <= 1'b0;
    end
    else if (load)
    begin
      pkt_poison <= (src_beat.poisoned | (pkt_poison & ~src_beat.sof))
                    & ~src_beat.eof; // R11
    end
  end

  // Track whether the user has taken part of a packet, for the abort.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_mid         <= 1'b0;
      rx_source_abort <= 1'b0;
    end
    else if (link_entering_reset)
    begin
      // Only a packet already begun needs an abort marker. R16
      rx_source_abort <= out_mid | (rx_source_valid & ~rx_start_of_frame);
      out_mid         <= 1'b0;
    end
    else
    begin
      rx_source_abort <= 1'b0;
      if (fire)
      begin
        out_mid <= ~rx_end_of_frame;
      end
    end
  end

  // Credit report follows the selector of the cycle before. R17
  always_comb
  begin
    next_credit = '0;
    unique case (credit_view_select) // R1
      TRP_VIEW_RX_SPACE:    next_credit = credit_views[0];
      TRP_VIEW_RX_GRANTED:  next_credit = credit_views[1];
      TRP_VIEW_RX_CONSUMED: next_credit = credit_views[2];
      TRP_VIEW_TX_AVAIL:    next_credit = credit_views[3];
      TRP_VIEW_TX_LIMIT:    next_credit = credit_views[4];
      TRP_VIEW_TX_CONSUMED: next_credit = credit_views[5];
      default:              next_credit = '0;
    endcase
  end

  // All six counters update together. R2 R3 R4
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      credit_out <= '0;
    end
    else
    begin
      credit_out <= next_credit; // R17
    end
  end

  // Link-up mirrors the active state, one register late. R5
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      link_up_status <= 1'b0;
    end
    else
    begin
      link_up_status <= (link_control_state_machine == TRP_LINK_ACTIVE_CODE); // R5
    end
  end

  // The user's non-posted ok is on pclk; the queue sees its inverse.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      nonposted_hold <= 1'b1;
    end
    else
    begin
      nonposted_hold <= ~nonposted_accept_ok; // R15
    end
  end

  // The return pulse comes from another clock, so it is synchronised.
  trp_sync #(
    .WIDTH (1)
  ) u_ret_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (posted_credit_return),
    .sync_out (ret_sync)
  );

  // Edge detect on the synchronised copy only.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ret_prev <= 1'b0;
    end
    else
    begin
      ret_prev <= ret_sync;
    end
  end

  assign ret_pulse = ret_sync & ~ret_prev;

  // A new return wins over a clear in the same cycle. R13
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      posted_return_pending <= 1'b0;
    end
    else if (ret_pulse)
    begin
      posted_return_pending <= 1'b1; // R13
    end
    else if (posted_credits_sent)
    begin
      posted_return_pending <= 1'b0; // R13
    end
  end

  // Count packets that completed toward the user.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pkt_count <= '0;
    end
    else if (apb_done & pwrite & (paddr == TRP_OFS_PKT_COUNT))
    begin
      pkt_count <= '0;
    end
    else if (fire & rx_end_of_frame)
    begin
      pkt_count <= pkt_count + 32'h0000_0001;
    end
  end

  // One wait state per access keeps read data coming from a register.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
    else
    begin
      pready  <= psel & penable & ~pready;
      pslverr <= 1'b0;
      prdata  <= '0;
      if (psel & penable & ~pready)
      begin
        unique case (paddr)
          TRP_OFS_CTRL:      prdata <= {28'h000_0000, ctrl};
          TRP_OFS_STATUS:    prdata <= {29'h0000_0000, out_mid,
                                        posted_return_pending, link_up_status};
          TRP_OFS_PKT_COUNT: prdata <= pkt_count;
          default:           pslverr <= 1'b1;
        endcase
      end
    end
  end

  // Control writes take effect only at the completing edge.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= TRP_CTRL_RESET;
    end
    else if (apb_done & pwrite & (paddr == TRP_OFS_CTRL))
    begin
      ctrl <= pwdata[3:0];
    end
  end

  property p_view_follow;
    @(posedge pclk) disable iff (!presetn)
    (credit_view_select == TRP_VIEW_TX_LIMIT) |=> (credit_out == $past(credit_views[4]));
  endproperty
  a_view_follow: assert property (p_view_follow) else $error("credit view lag wrong"); // R17

  property p_view_bad;
    @(posedge pclk) disable iff (!presetn)
    (credit_view_select == 3'h3 || credit_view_select == 3'h7) |=> (credit_out == '0);
  endproperty
  a_view_bad: assert property (p_view_bad) else $error("illegal view not zero"); // R1

  property p_link_up;
    @(posedge pclk) disable iff (!presetn)
    ##1 link_up_status == ($past(link_control_state_machine) == TRP_LINK_ACTIVE_CODE);
  endproperty
  a_link_up: assert property (p_link_up) else $error("link up mismatch"); // R5

  property p_pair;
    @(posedge pclk) disable iff (!presetn)
    (rx_source_valid && ctrl[TRP_CTRL_PAIR_LSB]) |-> (rx_region_hit[0] == rx_region_hit[1]);
  endproperty
  a_pair: assert property (p_pair) else $error("paired hit bits differ"); // R7

  property p_hold;
    @(posedge pclk) disable iff (!presetn)
    (rx_source_valid && !rx_user_ready && !link_entering_reset)
      |=> rx_source_valid && $stable(rx_packet_data) && $stable(rx_end_of_frame);
  endproperty
  a_hold: assert property (p_hold) else $error("beat changed while stalled"); // R8

  property p_crc_eof;
    @(posedge pclk) disable iff (!presetn)
    (rx_source_valid && rx_e2e_crc_error) |-> rx_end_of_frame;
  endproperty
  a_crc_eof: assert property (p_crc_eof) else $error("crc error off end beat"); // R10

  property p_poison;
    @(posedge pclk) disable iff (!presetn)
    (fire && rx_poisoned_flag && !rx_end_of_frame) ##1 rx_source_valid
      |-> rx_poisoned_flag || rx_start_of_frame;
  endproperty
  a_poison: assert property (p_poison) else $error("poison dropped mid packet"); // R11

  property p_pending;
    @(posedge pclk) disable iff (!presetn)
    ret_pulse |=> posted_return_pending ##1 (posted_return_pending || $past(posted_credits_sent));
  endproperty
  a_pending: assert property (p_pending) else $error("return pulse lost"); // R13

  property p_abort;
    @(posedge pclk) disable iff (!presetn)
    (link_entering_reset && out_mid) |=> rx_source_abort && !rx_source_valid && !out_mid;
  endproperty
  a_abort: assert property (p_abort) else $error("abort missing on link reset"); // R16

  property p_apb;
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready) |=> pready ##1 !pready;
  endproperty
  a_apb: assert property (p_apb) else $error("apb answer timing wrong");

endmodule

`default_nettype wire

/* sim/trp_user_app.sv */
/*
  User application model that takes receive beats from the block.
  Assumes it shares pclk and presetn with the block.
*/
`timescale 1ns/1ps
`default_nettype none

module trp_user_app
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic rx_source_valid,
  output var  logic rx_user_ready,
  output var  logic nonposted_accept_ok
);
  // Random stalls, because a sink that is always ready hides hold bugs.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rx_user_ready <= 1'b0;
    else
      rx_user_ready <= ($urandom_range(0, 3) != 0);
  end

  // Non-posted acceptance toggles freely; the block only mirrors it.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      nonposted_accept_ok <= 1'b1;
    else
      nonposted_accept_ok <= ($urandom_range(0, 1) != 0);
  end
endmodule

`default_nettype wire

/* sim/tb.sv */
/*
  Self-checking bench for the receive packet port block.
  Assumes trp_user_app stands in for the user side of the stream.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
  begin \
    n_tests++; \
    if ((g) !== (e)) \
    begin \
      error_cnt++; \
      $display("mismatch t=%0t got=%0h exp=%0h", $time, (g), (e)); \
    end \
  end

module tb
  import trp_pkg::*;
;
  logic            pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]      paddr;
  logic [31:0]     pwdata, prdata, n_eof, error_cnt, n_tests;
  trp_beat_t       src_beat, got_b, exp_b;
  logic            src_valid, src_ready, link_entering_reset, mon_on, np_prev;
  logic [2:0]      link_control_state_machine, credit_view_select;
  trp_credit_set_t credit_views [TRP_NUM_VIEWS];
  trp_credit_set_t credit_out;
  logic            posted_credits_sent, posted_return_pending, link_up_status;
  logic [127:0]    rx_packet_data;
  logic            rx_source_valid, rx_user_ready, rx_start_of_frame, rx_end_of_frame;
  logic [6:0]      rx_region_hit;
  logic            rx_e2e_crc_error, rx_poisoned_flag, rx_source_abort;
  logic            nonposted_accept_ok, nonposted_hold, posted_credit_return;
  trp_beat_t       exp_q [$];

  trp_top trp_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .src_beat, .src_valid, .src_ready, .link_entering_reset,
    .link_control_state_machine, .credit_views, .posted_credits_sent,
    .posted_return_pending, .credit_view_select, .credit_out, .link_up_status,
    .rx_packet_data, .rx_source_valid, .rx_user_ready, .rx_start_of_frame,
    .rx_end_of_frame, .rx_region_hit, .rx_e2e_crc_error, .rx_poisoned_flag,
    .rx_source_abort, .nonposted_accept_ok, .nonposted_hold, .posted_credit_return);

  trp_user_app trp_user_app_inst (.pclk, .presetn, .rx_source_valid, .rx_user_ready,
    .nonposted_accept_ok);

  // Free-running 100 MHz clock.
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Paired regions raise both hit bits when either half is hit.
  function automatic logic [6:0] exp_hit(logic [6:0] h, logic [2:0] pr);
    exp_hit = h;
    for (int k = 0; k < 3; k++)
      if (pr[k] && (h[2*k] || h[2*k+1]))
        exp_hit[2*k +: 2] = 2'b11;
  endfunction

  // Selector code to view; the two unused codes read as zero.
  function automatic trp_credit_set_t exp_view(logic [2:0] s);
    case (s)
      3'h0, 3'h1, 3'h2: exp_view = credit_views[s];
      3'h4, 3'h5, 3'h6: exp_view = credit_views[s - 3'h1];
      default: exp_view = '0;
    endcase
  endfunction

  task automatic results();
    $display("comparisons=%0d mismatches=%0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic timed_out();
    error_cnt++;
    results();
  endtask

  // APB transfer; starts at the next rising edge so back-to-back calls leave one idle cycle.
  // The request holds until pready is sampled high at a rising edge; data is taken there.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      timed_out();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Offers one beat and holds it until the block takes it.
  task automatic send(input trp_beat_t b);
    int n;
    src_beat <= b;
    src_valid <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (src_ready !== 1'b1 && n < 60);
    if (n >= 60)
      timed_out();
  endtask

  // Scoreboard: every beat the user takes must match the next expected one.
  always @(negedge pclk)
  begin
    if (mon_on && rx_source_valid === 1'b1 && rx_user_ready === 1'b1)
    begin
      got_b = {rx_packet_data, rx_start_of_frame, rx_end_of_frame, rx_region_hit,
               rx_e2e_crc_error, rx_poisoned_flag};
      exp_b = exp_q.size() ? exp_q.pop_front() : 'x;
      `CHK(got_b, exp_b)
      if (rx_end_of_frame)
        n_eof++;
    end
    if (mon_on)
      `CHK(nonposted_hold, ~np_prev)
    np_prev = nonposted_accept_ok;
  end

  initial
  begin
    int n, len;
    logic pz, ce, er, ab;
    logic [31:0] rd;
    logic [63:0] r;
    trp_beat_t b, e;
    void'($urandom(56));
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {src_beat, src_valid, link_entering_reset, link_control_state_machine} = '0;
    {posted_credits_sent, credit_view_select, posted_credit_return, mon_on} = '0;
    {n_eof, error_cnt, n_tests, np_prev} = '0;
    credit_views = '{default: '0};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, TRP_OFS_CTRL, 32'h0000_0000, rd, er);
    `CHK(rd, {28'h000_0000, TRP_CTRL_RESET})
    apb(1'b0, 8'h0C, 32'h0000_0000, rd, er);
    `CHK({er, rd}, {1'b1, 32'h0000_0000})
    apb(1'b1, TRP_OFS_CTRL, 32'h0000_0000, rd, er);
    @(negedge pclk);
    `CHK(src_ready, 1'b0)
    @(posedge pclk);
    apb(1'b1, TRP_OFS_CTRL, 32'h0000_000F, rd, er);
    mon_on = 1'b1;
    // Every selector and state code, with fresh random credit counts.
    for (int s = 0; s < 8; s++)
    begin
      foreach (credit_views[i])
      begin
        r = {$urandom, $urandom};
        credit_views[i] <= r[59:0];
      end
      credit_view_select <= 3'(s);
      link_control_state_machine <= 3'(s);
      @(posedge pclk);
      @(negedge pclk);
      `CHK(credit_out, exp_view(3'(s)))
      `CHK(link_up_status, 1'(s == TRP_LINK_ACTIVE_CODE))
      @(posedge pclk);
    end
    link_control_state_machine <= TRP_LINK_ACTIVE_CODE;
    // Random packets, back to back or with gaps; packet 0 hits a paired region.
    for (int p = 0; p < 10; p++)
    begin
      len = $urandom_range(1, 4);
      pz = 1'($urandom_range(0, 1));
      ce = 1'($urandom_range(0, 1));
      for (int i = 0; i < len; i++)
      begin
        b.data = {$urandom, $urandom, $urandom, $urandom};
        b.sof = (i == 0);
        b.eof = (i == len - 1);
        b.region_hit = (p == 0) ? 7'h01 : 7'($urandom);
        b.e2e_crc_error = ce && b.eof;
        b.poisoned = pz;
        e = b;
        e.region_hit = exp_hit(b.region_hit, 3'h7);
        exp_q.push_back(e);
        send(b);
      end
      if ($urandom_range(0, 1))
      begin
        src_valid <= 1'b0;
        @(posedge pclk);
      end
    end
    // Half a packet, then the link drops into reset in mid-packet.
    for (int i = 0; i < 2; i++)
    begin
      b = '{data: {4{$urandom}}, sof: (i == 0), region_hit: 7'h40, default: '0};
      exp_q.push_back(b);
      send(b);
    end
    src_valid <= 1'b0;
    n = 0;
    while (exp_q.size() != 0 && n < 300)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 300)
      timed_out();
    link_entering_reset <= 1'b1;
    @(posedge pclk);
    link_entering_reset <= 1'b0;
    ab = 1'b0;
    repeat (3) begin @(negedge pclk); ab |= rx_source_abort; end
    `CHK(ab, 1'b1)
    @(posedge pclk);
    // Posted credit return raises pending until the credits go out.
    posted_credit_return <= 1'b1;
    @(posedge pclk);
    posted_credit_return <= 1'b0;
    n = 0;
    do begin @(negedge pclk); n++; end while (posted_return_pending !== 1'b1 && n < 6);
    `CHK(posted_return_pending, 1'b1)
    @(posedge pclk);
    apb(1'b0, TRP_OFS_STATUS, 32'h0000_0000, rd, er);
    `CHK({rd[TRP_STAT_PENDING_BIT], rd[TRP_STAT_LINK_UP_BIT]}, 2'b11)
    posted_credits_sent <= 1'b1;
    @(posedge pclk);
    posted_credits_sent <= 1'b0;
    @(negedge pclk);
    `CHK(posted_return_pending, 1'b0)
    @(posedge pclk);
    apb(1'b0, TRP_OFS_PKT_COUNT, 32'h0000_0000, rd, er);
    `CHK(rd, 32'h0000_000A)
    `CHK(n_eof, 32'h0000_000A)
    apb(1'b1, TRP_OFS_PKT_COUNT, 32'h0000_0000, rd, er);
    apb(1'b0, TRP_OFS_PKT_COUNT, 32'h0000_0000, rd, er);
    `CHK(rd, 32'h0000_0000)
    results();
  end
endmodule

`default_nettype wire
